// ===== shared/dsc_pkg.sv
// Functional notes
// R1: Status bit 3 shows the direction of the latest bus access, 1 for a read and 0 for a write.
// R2: Status bits 2 to 0 show the number of the channel most recently active on the bus.
// R3: A read-only register holds the full 32-bit address of the latest access and resets to zero.
// R4: In append mode source data only feeds the checksum, and at block end the checksum is written to the channel destination start address.
// R5: With append mode clear, source data passes through the checksum and is also written out in the configured byte order.
// R6: The type-select bit picks an IP header checksum when 1 and an LFSR CRC when 0.
// R7: A 3-bit channel-select field attaches the checksum unit to exactly the channel whose number it holds.
// R8: While write byte order is 1, unaligned transfers are refused and the append-mode bit cannot be set.
// R9: In pattern-terminate mode the transferred data is compared against the 8-bit channel match value and a match ends the transfer.
// R10: In every other channel mode the channel match value is ignored.
// R11: The channel pattern register implements only bits 7 to 0, resets to zero, and reads zero above.
// R12: Last-access direction, channel and address are updated together on every bus access.
package dsc_pkg;

    localparam int unsigned NUM_CH    = 8;
    localparam int unsigned CH_W      = 3;
    localparam int unsigned ADDR_W    = 8;

    // Register offsets (byte addresses, one aligned word each).
    localparam logic [7:0] OFS_STATUS  = 8'h00;
    localparam logic [7:0] OFS_ADDR    = 8'h04;
    localparam logic [7:0] OFS_CKCTRL  = 8'h08;
    localparam logic [7:0] OFS_CKRES   = 8'h0c;
    localparam logic [7:0] OFS_CKSEED  = 8'h10;
    localparam logic [7:0] OFS_CHMODE  = 8'h14;
    localparam logic [7:0] OFS_PAT0    = 8'h20;

    // Field positions.
    localparam int unsigned POS_DIR    = 3;
    localparam int unsigned POS_APPEND = 6;
    localparam int unsigned POS_TYPE   = 5;
    localparam int unsigned POS_WBO    = 7;
    localparam int unsigned POS_CKEN   = 8;

    // Reset values and the CRC polynomial.
    localparam logic [31:0] RST_ADDR   = 32'h0000_0000;
    localparam logic [7:0]  RST_PAT    = 8'h00;
    localparam logic [15:0] RST_SEED   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'h1021;

    // Channel mode codes held two bits per channel in the mode register.
    localparam logic [1:0] MODE_PLAIN  = 2'h0;
    localparam logic [1:0] MODE_PATERM = 2'h1;

    // Register bus request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } dsc_reg_req_t;

    // One data beat from a channel engine.
    typedef struct packed {
        logic            valid;
        logic [CH_W-1:0] ch;
        logic [31:0]     addr;
        logic [31:0]     data;
        logic            is_read;
        logic            last;
        logic            unaligned;
    } dsc_beat_t;

    // One write issued toward the destination.
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
    } dsc_wr_t;

endpackage

// ===== hw/dsc_cksum.sv
// Checksum engine: one 32-bit word per enabled cycle.
module dsc_cksum
    import dsc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic        i_init,
    input  wire logic [15:0] i_seed,
    input  wire logic        i_type_ip,
    input  wire logic        i_step,
    input  wire logic [31:0] i_word,
    output logic      [15:0] o_result
);

    typedef struct packed {
        logic [15:0] crc;
        logic [16:0] sum;
    } dsc_ck_st_t;

    dsc_ck_st_t st_r;
    dsc_ck_st_t st_nxt;
    logic [15:0] crc_v;
    logic [16:0] s_v;

    // Bitwise LFSR over the word, MSB first; the IP sum folds its carry.
    always_comb begin
        crc_v  = st_r.crc;
        s_v    = st_r.sum;
        st_nxt = st_r;
        for (int b = 31; b >= 0; b--) begin
            crc_v = (crc_v[15] ^ i_word[b]) ? ((crc_v << 1) ^ CRC_POLY)
                                            : (crc_v << 1);
        end
        s_v = {1'b0, s_v[15:0]} + {16'h0000, s_v[16]};
        s_v = {1'b0, s_v[15:0]} + {1'b0, i_word[31:16]};
        s_v = {1'b0, s_v[15:0]} + {16'h0000, s_v[16]};
        s_v = {1'b0, s_v[15:0]} + {1'b0, i_word[15:0]};
        if (i_init) begin
            st_nxt.crc = i_seed;
            st_nxt.sum = 17'h0_0000;
        end else if (i_step) begin
            if (i_type_ip) begin // R6
                st_nxt.sum = s_v;
            end else begin
                st_nxt.crc = crc_v;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // IP result is the one's complement of the folded sum.
    assign o_result = i_type_ip
        ? ~(st_r.sum[15:0] + {15'h0000, st_r.sum[16]})
        : st_r.crc; // R6

endmodule

// ===== hw/dsc_top.sv
// Status, checksum routing and pattern match for the DMA channels.
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned P_NUM_CH = NUM_CH
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [31:0]       o_reg_rdata,
    input  wire dsc_beat_t         i_beat,
    input  wire logic [31:0]       i_dest_start,
    output dsc_wr_t                o_dest_wr,
    output logic                   o_beat_drop,
    output logic                   o_unaligned_err,
    output logic [P_NUM_CH-1:0]    o_match_term
);

    // Elaboration-time check on the channel count.
    if (P_NUM_CH != (1 << CH_W)) begin : g_bad_ch
        $error("P_NUM_CH must equal two to the channel field width");
    end

    typedef struct packed {
        logic [31:0]           rdata;
        logic                  dir;
        logic [CH_W-1:0]       ch;
        logic [31:0]           addr;
        logic                  append;
        logic                  ctype;
        logic                  write_byte_order;
        logic                  cken;
        logic [CH_W-1:0]       ck_ch;
        logic [15:0]           seed;
        logic [2*P_NUM_CH-1:0] mode;
        logic [8*P_NUM_CH-1:0] pat;
        dsc_wr_t               dwr;
        logic                  pend;
        logic                  drop;
        logic                  uerr;
        logic [P_NUM_CH-1:0]   term;
    } dsc_st_t;

    dsc_st_t     st_r;
    dsc_st_t     st_nxt;
    dsc_reg_req_t req;
    logic [15:0] ck_res;
    logic        ck_init;
    logic        ck_step;
    logic        on_ck;
    logic        wr_ck;
    logic [P_NUM_CH-1:0] hit;

    assign req = '{addr: i_reg_addr, wdata: i_reg_wdata,
                   wr: i_reg_wr, rd: i_reg_rd};

    // The checksum sees only beats of the attached channel.
    assign on_ck   = i_beat.valid && st_r.cken
                     && (i_beat.ch == st_r.ck_ch); // R7
    assign ck_step = on_ck && i_beat.is_read;
    assign wr_ck   = req.wr && (req.addr == OFS_CKCTRL);
    assign ck_init = wr_ck && req.wdata[POS_CKEN];

    dsc_cksum u_cksum (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_init    (ck_init),
        .i_seed    (st_r.seed),
        .i_type_ip (st_r.ctype),
        .i_step    (ck_step),
        .i_word    (i_beat.data),
        .o_result  (ck_res)
    );

    // Per-channel pattern compare on the low data byte; other modes
    // never look at the pattern, so a stale value cannot stop a channel.
    for (genvar c = 0; c < P_NUM_CH; c++) begin : g_match
        assign hit[c] = i_beat.valid && (i_beat.ch == CH_W'(c))
            && (st_r.mode[2*c +: 2] == MODE_PATERM) // R10
            && (i_beat.data[7:0] == st_r.pat[8*c +: 8]); // R9
    end

    // Next-state logic: register writes, status capture, routing.
    always_comb begin
        logic [31:0] rd_v;
        logic [CH_W-1:0] pidx;
        rd_v   = 32'h0000_0000;
        pidx   = '0;
        st_nxt = st_r;
        st_nxt.dwr.valid = 1'b0;
        st_nxt.drop      = 1'b0;
        st_nxt.uerr      = 1'b0;
        st_nxt.term      = hit; // R9

        // All three status fields move together on each access.
        if (i_beat.valid) begin
            st_nxt.dir  = i_beat.is_read; // R1 R12
            st_nxt.ch   = i_beat.ch; // R2 R12
            st_nxt.addr = i_beat.addr; // R3 R12
        end

        // Data path toward the destination.
        if (i_beat.valid && !i_beat.is_read) begin
            if (st_r.write_byte_order && i_beat.unaligned) begin
                st_nxt.uerr = 1'b1; // R8
                st_nxt.drop = 1'b1;
            end else if (on_ck && st_r.append) begin
                st_nxt.drop = 1'b1; // R4
            end else begin
                st_nxt.dwr.valid = 1'b1; // R5
                st_nxt.dwr.addr  = i_beat.addr;
                st_nxt.dwr.data  = st_r.write_byte_order
                    ? {i_beat.data[7:0], i_beat.data[15:8],
                       i_beat.data[23:16], i_beat.data[31:24]}
                    : i_beat.data; // R5
            end
        end

        // Append: arm at block end, write checksum one cycle later so
        // the final word has entered the engine first.
        if (on_ck && st_r.append && i_beat.last) begin
            st_nxt.pend = 1'b1; // R4
        end
        if (st_r.pend) begin
            st_nxt.pend      = 1'b0;
            st_nxt.dwr.valid = 1'b1;
            st_nxt.dwr.addr  = i_dest_start; // R4
            st_nxt.dwr.data  = {16'h0000, ck_res};
        end

        // Register writes.
        if (req.wr) begin
            case (req.addr)
                OFS_CKCTRL: begin
                    st_nxt.write_byte_order    = req.wdata[POS_WBO];
                    st_nxt.append = req.wdata[POS_APPEND]
                                    && !req.wdata[POS_WBO]; // R8
                    st_nxt.ctype  = req.wdata[POS_TYPE]; // R6
                    st_nxt.cken   = req.wdata[POS_CKEN];
                    st_nxt.ck_ch  = req.wdata[CH_W-1:0]; // R7
                end
                OFS_CKSEED: st_nxt.seed = req.wdata[15:0];
                OFS_CHMODE: st_nxt.mode = req.wdata[2*P_NUM_CH-1:0];
                default: begin
                    if (req.addr >= OFS_PAT0
                        && req.addr < OFS_PAT0 + 8'(4*P_NUM_CH)) begin
                        pidx = CH_W'((req.addr - OFS_PAT0) >> 2);
                        st_nxt.pat[8*pidx +: 8] = req.wdata[7:0]; // R11
                    end
                end
            endcase
        end

        // Read mux; unmapped offsets read zero.
        case (req.addr)
            OFS_STATUS: rd_v = {28'h000_0000, st_r.dir, st_r.ch}; // R1 R2
            OFS_ADDR:   rd_v = st_r.addr; // R3
            OFS_CKCTRL: rd_v = {23'h00_0000, st_r.cken, st_r.write_byte_order,
                                st_r.append, st_r.ctype, 2'h0,
                                st_r.ck_ch};
            OFS_CKRES:  rd_v = {16'h0000, ck_res};
            OFS_CKSEED: rd_v = {16'h0000, st_r.seed};
            OFS_CHMODE: rd_v = 32'(st_r.mode);
            default: begin
                if (req.addr >= OFS_PAT0
                    && req.addr < OFS_PAT0 + 8'(4*P_NUM_CH)) begin
                    pidx = CH_W'((req.addr - OFS_PAT0) >> 2);
                    rd_v = {24'h00_0000, st_r.pat[8*pidx +: 8]}; // R11
                end
            end
        endcase
        // Read data stands only in the cycle after the strobe.
        st_nxt.rdata = req.rd ? rd_v : 32'h0000_0000;
    end

    // Single state register; the clock enable freezes everything.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r      <= '0;
            st_r.addr <= RST_ADDR; // R3
            st_r.seed <= RST_SEED;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata     = st_r.rdata;
    assign o_dest_wr       = st_r.dwr;
    assign o_beat_drop     = st_r.drop;
    assign o_unaligned_err = st_r.uerr;
    assign o_match_term    = st_r.term;

endmodule

// ===== bench/dsc_props.sv
// Port-level checks for the DMA status, checksum and pattern block.
module dsc_props
    import dsc_pkg::*;
#(
    parameter int unsigned P_NUM_CH = NUM_CH
)
(
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire logic              i_ce,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0]       i_reg_wdata,
    input wire logic              i_reg_wr,
    input wire logic              i_reg_rd,
    input wire logic [31:0]       o_reg_rdata,
    input wire dsc_beat_t         i_beat,
    input wire logic [31:0]       i_dest_start,
    input wire dsc_wr_t           o_dest_wr,
    input wire logic              o_beat_drop,
    input wire logic              o_unaligned_err,
    input wire logic [P_NUM_CH-1:0] o_match_term
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // A beat, one idle cycle, then a read of the given register.
    sequence s_beat_rd(logic [7:0] a);
        i_ce && i_beat.valid ##1 i_ce && !i_beat.valid
            ##1 i_ce && i_reg_rd && i_reg_addr == a;
    endsequence

    property p_stat;
        s_beat_rd(OFS_STATUS) |=> o_reg_rdata ==
            {28'h0, $past(i_beat.is_read, 3), $past(i_beat.ch, 3)};
    endproperty
    a_stat: assert property (p_stat) else $error("status mismatch");
    property p_addr;
        s_beat_rd(OFS_ADDR) |=> o_reg_rdata == $past(i_beat.addr, 3);
    endproperty
    a_addr: assert property (p_addr) else $error("address mismatch");
    property p_pat_hi;
        i_ce && i_reg_rd && i_reg_addr >= OFS_PAT0 |=> o_reg_rdata[31:8] == 24'h0;
    endproperty
    a_pat_hi: assert property (p_pat_hi) else $error("pattern high bits");
    // The extra term keeps a pending checksum write out of the way.
    property p_fwd;
        i_ce && i_beat.valid && !i_beat.is_read && !$past(i_beat.last) |=>
            !o_dest_wr.valid || o_dest_wr.addr == $past(i_beat.addr);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward address");
    property p_nofwd;
        i_ce && i_beat.valid && i_beat.is_read && !$past(i_beat.last) |=>
            !o_dest_wr.valid;
    endproperty
    a_nofwd: assert property (p_nofwd) else $error("read beat written");
    // A low enable holds a pulse, so only a freshly launched one is judged.
    property p_drop;
        o_beat_drop && $past(i_ce) |->
            $past(i_beat.valid && !i_beat.is_read);
    endproperty
    a_drop: assert property (p_drop) else $error("drop without beat");
    property p_uerr;
        o_unaligned_err && $past(i_ce) |->
            o_beat_drop && $past(i_beat.unaligned);
    endproperty
    a_uerr: assert property (p_uerr) else $error("bad unaligned error");
    property p_match;
        o_match_term != '0 && $past(i_ce) |-> $past(i_beat.valid) &&
            o_match_term ==
            ({{(P_NUM_CH-1){1'b0}}, 1'b1} << $past(i_beat.ch));
    endproperty
    a_match: assert property (p_match) else $error("bad match channel");
endmodule

// ===== bench/dsc_far.sv
// Memory on the system bus that receives the block's destination writes.
module dsc_far
    import dsc_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rstn,
    input  wire dsc_wr_t i_wr,
    output dsc_wr_t      o_last,
    output logic [7:0]   o_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // It has no wait state, since the block offers no way to stall it.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_last  <= '0;
            o_count <= 8'h00;
        end else if (i_wr.valid) begin
            o_last  <= i_wr;
            o_count <= o_count + 8'h01;
        end
    end
endmodule

// ===== bench/dsc_top_tb.sv
module dsc_top_tb import dsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk, i_rstn, i_ce, rd, wr, drop, uerr;
    logic [7:0]  addr, term, cnt;
    logic [31:0] wdata, rdata, dstart, got;
    dsc_beat_t   beat;
    dsc_wr_t     dwr, last;
    int          mismatches, checks_done;

    dsc_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_beat(beat),
        .i_dest_start(dstart), .o_dest_wr(dwr), .o_beat_drop(drop),
        .o_unaligned_err(uerr), .o_match_term(term));
    dsc_far u_far (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr(dwr),
        .o_last(last), .o_count(cnt));

    // Free-running 10 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    // Read data is sampled mid-cycle, once the edge's updates have landed.
    task automatic reg_rd(logic [7:0] a);
        @(posedge i_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        @(negedge i_clk);
        got = rdata;
    endtask
    task automatic send(logic [2:0] c, logic [31:0] a, d, logic r, l, u);
        @(posedge i_clk);
        beat <= '{1'b1, c, a, d, r, l, u};
        @(posedge i_clk);
        beat.valid <= 1'b0;
        @(negedge i_clk);
    endtask
    function automatic logic [15:0] crc(logic [15:0] c, logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0);
        return c;
    endfunction

    task automatic t_reset;
        reg_rd(OFS_STATUS);
        cmp("status", 32'h0, got);
        reg_rd(OFS_ADDR);
        cmp("address", 32'h0, got);
        reg_rd(OFS_PAT0 + 8'h0c);
        cmp("pattern", 32'h0, got);
    endtask
    task automatic t_status;
        for (int c = 0; c < 8; c++) begin
            send(c[2:0], 32'h1000_0000 + 32'(c), 32'h0, c[0], 1'b0, 1'b0);
            reg_rd(OFS_STATUS);
            cmp("status", {28'h0, c[0], c[2:0]}, got);
            reg_rd(OFS_ADDR);
            cmp("address", 32'h1000_0000 + 32'(c), got);
        end
        // A beat offered while the enable is low must leave no trace.
        @(posedge i_clk);
        i_ce <= 1'b0;
        send(3'h6, 32'h5555_0000, 32'h0, 1'b0, 1'b0, 1'b0);
        @(posedge i_clk);
        i_ce <= 1'b1;
        reg_rd(OFS_ADDR);
        cmp("frozen address", 32'h1000_0007, got);
    endtask
    task automatic t_path;
        send(3'h4, 32'h0000_2000, 32'h1122_3344, 1'b0, 1'b0, 1'b0);
        @(negedge i_clk);
        cmp("dest addr", 32'h0000_2000, last.addr);
        cmp("dest data", 32'h1122_3344, last.data);
        reg_wr(OFS_CKCTRL, 32'h0000_00c0);
        reg_rd(OFS_CKCTRL);
        cmp("control", 32'h0000_0080, got);
        send(3'h4, 32'h0000_2004, 32'h1122_3344, 1'b0, 1'b0, 1'b0);
        @(negedge i_clk);
        cmp("swapped", 32'h4433_2211, last.data);
        send(3'h4, 32'h0000_2009, 32'h1122_3344, 1'b0, 1'b0, 1'b1);
        cmp("refused", 32'h3, {30'h0, uerr, drop});
        cmp("writes", 32'h6, {24'h0, cnt});
    endtask
    task automatic t_pattern;
        reg_wr(OFS_PAT0 + 8'h0c, 32'hffff_ffa5);
        reg_rd(OFS_PAT0 + 8'h0c);
        cmp("pattern", 32'h0000_00a5, got);
        send(3'h3, 32'h0, 32'h0000_00a5, 1'b0, 1'b0, 1'b0);
        cmp("plain", 32'h0, {24'h0, term});
        reg_wr(OFS_CHMODE, 32'h0000_0040);
        send(3'h3, 32'h0, 32'h0000_005a, 1'b0, 1'b0, 1'b0);
        cmp("no match", 32'h0, {24'h0, term});
        send(3'h3, 32'h0, 32'h1234_56a5, 1'b0, 1'b0, 1'b0);
        cmp("match", 32'h8, {24'h0, term});
    endtask
    // Channel 2 traffic must not reach a unit attached to channel 5.
    task automatic t_append(logic ip);
        logic [15:0] c;
        logic [7:0]  n;
        logic [31:0] e;
        c = crc(crc(RST_SEED, 32'hdead_beef), 32'h0bad_f00d);
        // Folded sum of dead, beef, 0bad and f00d is 9958, then inverted.
        e = ip ? 32'h0000_66a7 : {16'h0, c};
        reg_wr(OFS_CKCTRL, {23'h0, 1'b1, 1'b0, 1'b1, ip, 5'h5});
        n = cnt;
        send(3'h5, 32'h0000_3000, 32'h0, 1'b0, 1'b0, 1'b0);
        cmp("append drop", 32'h1, {31'h0, drop});
        send(3'h2, 32'h0, 32'h0000_1111, 1'b1, 1'b1, 1'b0);
        send(3'h5, 32'h0000_3004, 32'hdead_beef, 1'b1, 1'b0, 1'b0);
        send(3'h5, 32'h0000_3008, 32'h0bad_f00d, 1'b1, 1'b1, 1'b0);
        repeat (2) @(negedge i_clk);
        cmp("sum addr", dstart, last.addr);
        cmp("sum writes", {24'h0, n + 8'h01}, {24'h0, cnt});
        cmp("sum data", e, last.data);
        reg_rd(OFS_CKRES);
        cmp("sum result", e, got);
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence: two cycles of reset, then the scenarios.
    initial begin
        mismatches  = 0;
        checks_done = 0;
        i_rstn = 1'b0;
        i_ce   = 1'b1;
        rd     = 1'b0;
        wr     = 1'b0;
        addr   = 8'h00;
        wdata  = 32'h0;
        beat   = '0;
        dstart = 32'h0000_8000;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset;
        t_status;
        t_path;
        t_pattern;
        t_append(1'b0);
        t_append(1'b1);
        // Second reset in mid-run: status, address and pattern clear.
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset;
        wrap_up;
    end
    // A hang is cut short well inside the run budget.
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        wrap_up;
    end
endmodule

bind dsc_top dsc_props #(.P_NUM_CH(P_NUM_CH)) u_props (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_beat(i_beat), .i_dest_start(i_dest_start),
    .o_dest_wr(o_dest_wr), .o_beat_drop(o_beat_drop),
    .o_unaligned_err(o_unaligned_err), .o_match_term(o_match_term));
